// >>> hw/rct_timer.sv
// Summary of operation
// - timer function counts every clock, divided by prescale 1 to 16
// - counter function samples count pin each clock, counts on high-then-low
// - incremented value visible the cycle after the falling edge is detected
// - mode: baud if either select, else capture, up/down, or plain reload
// - run bit 2 starts counting; clear stops the timer in every mode
// - minimum 0000, maximum ffff, bottom is the reload/capture pair
// - overflow flag bit 7 set on overflow, software clear, not in baud
// - event flag bit 6 set by qualified trigger edge, which captures/reloads outside baud mode
// - set event flag requests timer interrupt when interrupt enabled
// - event flag requests no interrupt while up/down counting enabled
// - receive select bit 5 picks this timer's overflows, else other timer
// - transmit select bit 4 picks this timer's overflows, else other timer
// - external enable bit 3 allows trigger edge events, else ignored
// - source select bit 1: 0 internal clock, 1 count pin falling edges
// - capture select bit 0: 1 trigger captures, 0 reloads on overflow/trigger
// - in baud mode capture select ignored, reload on overflow
// - toggle enable with internal source toggles count pin each overflow
// - down-count enable with external enable: trigger pin sets direction
// - count high byte at index cd, low byte at cc
// - reload/capture high byte at index cb, low byte at ca
// - control and mode registers reset to zero
// - capture copies count high and low into reload/capture registers
// - down count underflows at bottom, sets flag, loads max; event flag toggles
// - in baud mode trigger edge sets event flag without reload
// - up-count overflow from max loads bottom, or loads minimum 0000 in capture mode
`timescale 1ns/1ps
`include "rct_cfg.svh"

module rct_timer
(
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// apb register port
	input rct_pkg::rct_apb_req_s APB_REQ,
	output rct_pkg::rct_apb_rsp_s APB_RSP,
	// count pin, three signals
	input wire logic COUNT_PIN_IN,
	output logic COUNT_PIN_OUT,
	output logic COUNT_PIN_OE_N,
	// trigger pin
	input wire logic TRIG_PIN_IN,
	// interrupt request to the core
	input wire logic INT_ENABLE,
	output logic TIMER_IRQ,
	// serial port baud clocks
	input wire logic OTHER_TIMER_OVF,
	output logic RX_BAUD_CLK,
	output logic TX_BAUD_CLK
);
	import rct_pkg::*;

	function automatic logic hit(input logic [`RCT_ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == {2'b00, idx, 2'b00});
	endfunction

	// control fields
	logic ovf_flag;
	logic ext_flag;
	logic rx_sel;
	logic tx_sel;
	logic ext_en;
	logic run;
	logic csrc;
	logic cprl;
	logic toe;
	logic down_count_enable;
	logic [3:0] presc;
	logic [3:0] presc_cnt;
	logic [15:0] count;
	logic [15:0] rcap;
	logic pin_q;
	logic trig_q;
	logic pin_out;
	logic ovf_q;
	logic [31:0] prdata;

	// bus decode
	wire logic [`RCT_ADDR_W-1:0] addr = APB_REQ.paddr;
	wire logic [7:0] wbyte = APB_REQ.pwdata[7:0];
	wire logic setup = APB_REQ.psel & ~APB_REQ.penable;
	wire logic wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
	wire logic h_ctrl = hit(addr, `RCT_IDX_CTRL);
	wire logic h_mode = hit(addr, `RCT_IDX_MODE);
	wire logic h_rl = hit(addr, `RCT_IDX_RCAP_L);
	wire logic h_rh = hit(addr, `RCT_IDX_RCAP_H);
	wire logic h_cl = hit(addr, `RCT_IDX_CNT_L);
	wire logic h_ch = hit(addr, `RCT_IDX_CNT_H);
	wire logic h_ps = hit(addr, `RCT_IDX_PRESC);
	wire logic mapped = h_ctrl | h_mode | h_rl | h_rh | h_cl | h_ch | h_ps;
	wire logic wr_ctrl = wr & h_ctrl;
	wire logic wr_mode = wr & h_mode;
	wire logic wr_rl = wr & h_rl;
	wire logic wr_rh = wr & h_rh;
	wire logic wr_cl = wr & h_cl;
	wire logic wr_ch = wr & h_ch;
	wire logic wr_ps = wr & h_ps;
	wire logic wr_cnt = wr_cl | wr_ch;
	wire logic wr_rcap = wr_rl | wr_rh;

	// read data
	wire logic [7:0] ctrl_rd = {ovf_flag, ext_flag, rx_sel, tx_sel, ext_en, run, csrc, cprl};
	wire logic [7:0] mode_rd = {6'h00, toe, down_count_enable};
	wire logic [7:0] rd_byte =
		h_ctrl ? ctrl_rd :
		h_mode ? mode_rd :
		h_rl ? rcap[7:0] :
		h_rh ? rcap[15:8] :
		h_cl ? count[7:0] :
		h_ch ? count[15:8] :
		h_ps ? {4'h0, presc} :
		8'h00;

	// mode selection
	wire logic baud = rx_sel | tx_sel;
	wire rct_mode_e mode =
		baud ? RCT_BAUD :
		cprl ? RCT_CAPTURE :
		down_count_enable ? RCT_UPDOWN :
		RCT_RELOAD;
	wire logic [15:0] bottom = rcap;

	// edge detection on synchronous pin samples
	wire logic pin_fall = pin_q & ~COUNT_PIN_IN;
	wire logic trig_fall = trig_q & ~TRIG_PIN_IN;

	// count tick
	wire logic presc_tick = (presc_cnt == presc);
	wire logic tick = run & (csrc ? pin_fall : presc_tick);
	wire logic down = (mode == RCT_UPDOWN) & ext_en & ~TRIG_PIN_IN;
	wire logic ovf = tick & ~down & (count == `RCT_CNT_MAX);
	wire logic unf = tick & down & (count == bottom);
	wire logic roll = ovf | unf;

	// trigger pin events; in up/down the pin is only a direction
	wire logic trig_evt = run & ext_en & trig_fall & (mode != RCT_UPDOWN);
	wire logic cap_evt = trig_evt & (mode == RCT_CAPTURE);
	wire logic reload_evt = (ovf & (mode != RCT_CAPTURE))
		| (trig_evt & (mode == RCT_RELOAD));

	// next count, hardware first, then any byte write on top
	wire logic [15:0] next_hw =
		unf ? `RCT_CNT_MAX :
		reload_evt ? bottom :
		ovf ? `RCT_CNT_MIN :
		tick ? (down ? count - 16'h0001 : count + 16'h0001) :
		count;
	wire logic [15:0] next_count = {wr_ch ? wbyte : next_hw[15:8], wr_cl ? wbyte : next_hw[7:0]};

	// reload/capture pair
	wire logic [15:0] next_rcap =
		cap_evt ? count :
		{wr_rh ? wbyte : rcap[15:8], wr_rl ? wbyte : rcap[7:0]};

	// flags: hardware set wins over a software clear in the same cycle
	wire logic ovf_base = wr_ctrl ? wbyte[`RCT_CTRL_OVF] : ovf_flag;
	wire logic next_ovf_flag = (roll & ~baud) | ovf_base;
	wire logic ext_base = wr_ctrl ? wbyte[`RCT_CTRL_EXF] : ext_flag;
	wire logic ext_toggle = roll & (mode == RCT_UPDOWN);
	wire logic next_ext_flag =
		ext_toggle ? ~ext_flag :
		trig_evt ? 1'b1 :
		ext_base;

	// prescaler restarts when stopped so the first period is whole
	wire logic [3:0] next_presc_cnt = (presc_tick | ~run) ? 4'h0 : presc_cnt + 4'h1;

	// clock-out toggle only when the pin is not a count input
	wire logic drive_pin = toe & ~csrc;
	wire logic next_pin_out = (drive_pin & roll) ? ~pin_out : pin_out;

	// software fields hold unless their own register is written
	wire logic [5:0] next_ctrl_cfg =
		wr_ctrl ? wbyte[5:0] : {rx_sel, tx_sel, ext_en, run, csrc, cprl};
	wire logic [1:0] next_mode_cfg = wr_mode ? wbyte[1:0] : {toe, down_count_enable};
	wire logic [3:0] next_presc = wr_ps ? wbyte[3:0] : presc;

	// control and mode registers
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			{ovf_flag, ext_flag, rx_sel, tx_sel, ext_en, run, csrc, cprl} <= `RCT_CTRL_RST;
			{toe, down_count_enable} <= 2'b00;
			presc <= `RCT_PRESC_RST;
		end
		else
		begin
			ovf_flag <= next_ovf_flag;
			ext_flag <= next_ext_flag;
			{rx_sel, tx_sel, ext_en, run, csrc, cprl} <= next_ctrl_cfg;
			{toe, down_count_enable} <= next_mode_cfg;
			presc <= next_presc;
		end
	end

	// counting datapath; count and pair have no documented reset, zero is chosen
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			count <= 16'h0000;
			rcap <= 16'h0000;
			presc_cnt <= 4'h0;
			pin_q <= 1'b0;
			trig_q <= 1'b0;
			pin_out <= 1'b1;
			ovf_q <= 1'b0;
		end
		else
		begin
			count <= next_count;
			rcap <= next_rcap;
			presc_cnt <= next_presc_cnt;
			pin_q <= COUNT_PIN_IN;
			trig_q <= TRIG_PIN_IN;
			pin_out <= next_pin_out;
			ovf_q <= roll;
		end
	end

	// read data captured in setup, so the access phase needs no wait
	wire logic [31:0] next_prdata = setup ? {24'h00_0000, rd_byte} : prdata;
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			prdata <= 32'h0000_0000;
		else
			prdata <= next_prdata;
	end

	assign APB_RSP.pready = 1'b1;
	assign APB_RSP.pslverr = APB_REQ.psel & APB_REQ.penable & ~mapped;
	assign APB_RSP.prdata = prdata;

	// pin and system outputs
	assign COUNT_PIN_OUT = pin_out;
	assign COUNT_PIN_OE_N = ~drive_pin;
	assign TIMER_IRQ = INT_ENABLE & (ovf_flag | (ext_flag & ~down_count_enable));
	assign RX_BAUD_CLK = rx_sel ? ovf_q : OTHER_TIMER_OVF;
	assign TX_BAUD_CLK = tx_sel ? ovf_q : OTHER_TIMER_OVF;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);

	property p_ovf_sets;
		ovf && !baud |=> ovf_flag;
	endproperty
	a_ovf_sets: assert property (p_ovf_sets)
		else $error("overflow did not set flag");

	property p_no_ovf_baud;
		baud && !ovf_flag && !wr_ctrl |=> !ovf_flag;
	endproperty
	a_no_ovf_baud: assert property (p_no_ovf_baud)
		else $error("overflow flag set in baud mode");

	property p_stopped;
		!run && !wr_cnt |=> $stable(count);
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("count moved while stopped");

	property p_capture;
		cap_evt |=> rcap == $past(count);
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture value wrong");

	property p_reload;
		ovf && mode == RCT_RELOAD && !wr_cnt && !wr_rcap |=> count == $past(bottom);
	endproperty
	a_reload: assert property (p_reload)
		else $error("reload value wrong");

	property p_underflow;
		unf && !wr_cnt && !wr_ctrl |=> count == 16'hffff && ovf_flag;
	endproperty
	a_underflow: assert property (p_underflow)
		else $error("underflow handling wrong");

	property p_pin_count;
		run && csrc && pin_q && !COUNT_PIN_IN && !down && count != 16'hffff && !wr_cnt
			&& !reload_evt
			|=> count == $past(count) + 16'h0001;
	endproperty
	a_pin_count: assert property (p_pin_count)
		else $error("falling edge not counted next cycle");

	property p_irq;
		(ext_flag && INT_ENABLE && !down_count_enable |-> TIMER_IRQ) and (down_count_enable && !ovf_flag |-> !TIMER_IRQ);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request wrong");

	property p_toggle;
		roll && drive_pin |=> COUNT_PIN_OUT != $past(COUNT_PIN_OUT);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("clock-out pin did not toggle");

	property p_baud_tick;
		rx_sel && roll |=> RX_BAUD_CLK;
	endproperty
	a_baud_tick: assert property (p_baud_tick)
		else $error("receive baud clock missing");

	property p_tx_tick;
		tx_sel && roll |=> TX_BAUD_CLK;
	endproperty
	a_tx_tick: assert property (p_tx_tick)
		else $error("transmit baud clock missing");

	property p_count_up;
		tick && !down && !ovf && !reload_evt && !wr_cnt |=> count == $past(count) + 16'h0001;
	endproperty
	a_count_up: assert property (p_count_up)
		else $error("count did not advance on tick");

	property p_down_step;
		tick && down && !unf && !wr_cnt |=> count == $past(count) - 16'h0001;
	endproperty
	a_down_step: assert property (p_down_step)
		else $error("count did not step down");

	property p_presc_gap;
		run && presc_tick && presc != 4'h0 && !wr_ps |=> !presc_tick;
	endproperty
	a_presc_gap: assert property (p_presc_gap)
		else $error("prescaler ticked twice in a row");

	property p_baud_reload;
		ovf && baud && !wr_cnt && !wr_rcap |=> count == $past(bottom);
	endproperty
	a_baud_reload: assert property (p_baud_reload)
		else $error("baud rollover did not reload");

	property p_no_reload_baud;
		baud && trig_evt && !tick && !wr_cnt |=> $stable(count);
	endproperty
	a_no_reload_baud: assert property (p_no_reload_baud)
		else $error("trigger reloaded count in baud mode");

	property p_ext_set;
		trig_evt |=> ext_flag;
	endproperty
	a_ext_set: assert property (p_ext_set)
		else $error("trigger event did not set event flag");

	property p_trig_ignored;
		!ext_en && !wr_ctrl && !ext_toggle |=> $stable(ext_flag);
	endproperty
	a_trig_ignored: assert property (p_trig_ignored)
		else $error("event flag moved with external enable clear");

	property p_ext_toggle;
		ext_toggle |=> ext_flag != $past(ext_flag);
	endproperty
	a_ext_toggle: assert property (p_ext_toggle)
		else $error("event flag did not toggle on roll");

	property p_stop_flag;
		!run && !wr_ctrl |=> $stable(ovf_flag);
	endproperty
	a_stop_flag: assert property (p_stop_flag)
		else $error("overflow flag moved while stopped");

	property p_mode_read;
		setup && h_mode |=> APB_RSP.prdata[7:2] == 6'h00;
	endproperty
	a_mode_read: assert property (p_mode_read)
		else $error("unused mode bits read nonzero");

endmodule

// >>> hw/rct_cfg.svh
`ifndef RCT_CFG_SVH
`define RCT_CFG_SVH

// apb address width and register indexes (byte address is index times four)
`define RCT_ADDR_W 12
`define RCT_IDX_CTRL 8'hc8
`define RCT_IDX_MODE 8'hc9
`define RCT_IDX_RCAP_L 8'hca
`define RCT_IDX_RCAP_H 8'hcb
`define RCT_IDX_CNT_L 8'hcc
`define RCT_IDX_CNT_H 8'hcd
`define RCT_IDX_PRESC 8'hce

// timer_control bit positions
`define RCT_CTRL_OVF 7
`define RCT_CTRL_EXF 6
`define RCT_CTRL_RXSEL 5
`define RCT_CTRL_TXSEL 4
`define RCT_CTRL_EXEN 3
`define RCT_CTRL_RUN 2
`define RCT_CTRL_CSRC 1
`define RCT_CTRL_CPRL 0

// timer_mode_control bit positions
`define RCT_MODE_TOE 1
`define RCT_MODE_DOWN_COUNT_ENABLE 0

// reset values and count limits
`define RCT_CTRL_RST 8'h00
`define RCT_MODE_RST 8'h00
`define RCT_PRESC_RST 4'h0
`define RCT_CNT_MIN 16'h0000
`define RCT_CNT_MAX 16'hffff

`endif

// >>> hw/rct_pkg.sv
`include "rct_cfg.svh"

package rct_pkg;

	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [`RCT_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} rct_apb_req_s;

	typedef struct packed
	{
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} rct_apb_rsp_s;

	typedef enum logic [1:0]
	{
		RCT_RELOAD,
		RCT_UPDOWN,
		RCT_CAPTURE,
		RCT_BAUD
	} rct_mode_e;

endpackage

// >>> sim/rct_core_model.sv
`timescale 1ns/1ps
module rct_core_model
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// external count source
	input wire logic src_en,
	output logic src_lvl,
	// serial port side
	output logic other_ovf,
	input wire logic rx_clk,
	input wire logic tx_clk,
	output int edges,
	output int others,
	output int rx_n,
	output int tx_n
);
	logic [1:0] ph;
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ph <= 2'h0;
			src_lvl <= 1'b1;
			other_ovf <= 1'b0;
			edges <= 0;
			others <= 0;
			rx_n <= 0;
			tx_n <= 0;
		end
		else
		begin
			ph <= ph + 2'h1;
			// two clocks per level so no level slips between samples
			src_lvl <= src_en ? ~ph[1] : 1'b1;
			edges <= edges + int'(src_en && src_lvl && ph[1]);
			other_ovf <= (ph == 2'h3);
			others <= others + int'(other_ovf);
			rx_n <= rx_n + int'(rx_clk);
			tx_n <= tx_n + int'(tx_clk);
		end
	end
endmodule

// >>> sim/rct_timer_tb_top.sv
`timescale 1ns/1ps
`include "rct_cfg.svh"
`define RCT_CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module rct_timer_tb_top;
	import rct_pkg::*;
	logic CLK = 1'b0;
	logic ARST_N = 1'b0;
	rct_apb_req_s req = '0;
	rct_apb_rsp_s rsp;
	logic trig = 1'b1;
	logic inten = 1'b1;
	logic src_en = 1'b0;
	logic pin_out, oe_n, irq, rxc, txc, oovf, src, pin;
	int edges, others, rx_n, tx_n, miscompares, compares, a0, b0, d0;
	logic [7:0] v, c;
	// pin level: ours while driving, otherwise the outside source
	assign pin = oe_n ? src : pin_out;
	rct_timer uut(.CLK(CLK), .ARST_N(ARST_N), .APB_REQ(req), .APB_RSP(rsp),
		.COUNT_PIN_IN(pin), .COUNT_PIN_OUT(pin_out), .COUNT_PIN_OE_N(oe_n),
		.TRIG_PIN_IN(trig), .INT_ENABLE(inten), .TIMER_IRQ(irq),
		.OTHER_TIMER_OVF(oovf), .RX_BAUD_CLK(rxc), .TX_BAUD_CLK(txc));
	rct_core_model core(.clk(CLK), .arst_n(ARST_N), .src_en(src_en), .src_lvl(src),
		.other_ovf(oovf), .rx_clk(rxc), .tx_clk(txc), .edges(edges), .others(others),
		.rx_n(rx_n), .tx_n(tx_n));
	initial
	begin
		forever #2 CLK = ~CLK;
	end
	task automatic close_out;
		if (miscompares == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
		output logic [7:0] r, output logic e);
		int n;
		@(posedge CLK);
		req <= {1'b1, 1'b0, w, {2'h0, i, 2'h0}, {24'h0, d}};
		@(posedge CLK);
		req.penable <= 1'b1;
		n = 0;
		@(posedge CLK);
		while (rsp.pready !== 1'b1 && n < 20)
		begin
			@(posedge CLK);
			n++;
		end
		if (n == 20)
		begin
			miscompares++;
			close_out();
		end
		r = rsp.prdata[7:0];
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] r;
		logic e;
		apb(1'b1, i, d, r, e);
	endtask
	task automatic rdv(input logic [7:0] i, output logic [7:0] r);
		logic e;
		apb(1'b0, i, 8'h00, r, e);
	endtask
	task automatic rdc(input logic [7:0] i, input logic [7:0] x);
		logic [7:0] r;
		rdv(i, r);
		`RCT_CHK(r, x)
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic trig_fall;
		trig <= 1'b0;
		cyc(3);
		trig <= 1'b1;
		cyc(3);
	endtask
	task automatic t_regs;
		logic e;
		rdc(`RCT_IDX_CTRL, 8'h00);
		rdc(`RCT_IDX_MODE, 8'h00);
		wr(`RCT_IDX_MODE, 8'hff);
		rdc(`RCT_IDX_MODE, 8'h03);
		wr(`RCT_IDX_MODE, 8'h00);
		wr(`RCT_IDX_RCAP_L, 8'h5a);
		rdc(`RCT_IDX_RCAP_L, 8'h5a);
		wr(`RCT_IDX_CNT_H, 8'ha5);
		rdc(`RCT_IDX_CNT_H, 8'ha5);
		apb(1'b1, 8'hd0, 8'h11, v, e);
		apb(1'b0, 8'hd0, 8'h00, v, e);
		`RCT_CHK(e, 1'b1)
		`RCT_CHK(v, 8'h00)
	endtask
	task automatic t_presc;
		wr(`RCT_IDX_CNT_L, 8'h00);
		wr(`RCT_IDX_CNT_H, 8'h00);
		wr(`RCT_IDX_PRESC, 8'h0f);
		wr(`RCT_IDX_CTRL, 8'h04);
		cyc(157);
		wr(`RCT_IDX_CTRL, 8'h00);
		rdv(`RCT_IDX_CNT_L, v);
		`RCT_CHK(v >= 8'h09 && v <= 8'h0b, 1'b1)
		cyc(40);
		rdc(`RCT_IDX_CNT_L, v);
		wr(`RCT_IDX_PRESC, 8'h00);
	endtask
	task automatic t_counter;
		wr(`RCT_IDX_CNT_L, 8'h00);
		wr(`RCT_IDX_CTRL, 8'h06);
		src_en <= 1'b1;
		cyc(41);
		src_en <= 1'b0;
		cyc(4);
		rdc(`RCT_IDX_CNT_L, edges[7:0]);
		wr(`RCT_IDX_CTRL, 8'h00);
	endtask
	task automatic t_reload;
		wr(`RCT_IDX_RCAP_L, 8'h00);
		wr(`RCT_IDX_RCAP_H, 8'hab);
		wr(`RCT_IDX_CNT_L, 8'hfc);
		wr(`RCT_IDX_CNT_H, 8'hff);
		wr(`RCT_IDX_MODE, 8'h02);
		cyc(1);
		`RCT_CHK(oe_n, 1'b0)
		c[0] = pin_out;
		wr(`RCT_IDX_CTRL, 8'h04);
		cyc(10);
		rdc(`RCT_IDX_CTRL, 8'h84);
		`RCT_CHK(irq, 1'b1)
		`RCT_CHK(pin_out, ~c[0])
		rdc(`RCT_IDX_CNT_H, 8'hab);
		wr(`RCT_IDX_CTRL, 8'h00);
		wr(`RCT_IDX_MODE, 8'h00);
	endtask
	task automatic t_capture;
		wr(`RCT_IDX_RCAP_L, 8'h00);
		wr(`RCT_IDX_RCAP_H, 8'h00);
		wr(`RCT_IDX_CNT_L, 8'h00);
		wr(`RCT_IDX_CNT_H, 8'h00);
		wr(`RCT_IDX_CTRL, 8'h05);
		trig_fall();
		rdc(`RCT_IDX_CTRL, 8'h05);
		rdc(`RCT_IDX_RCAP_L, 8'h00);
		wr(`RCT_IDX_CTRL, 8'h0d);
		trig_fall();
		rdv(`RCT_IDX_RCAP_L, v);
		rdv(`RCT_IDX_CNT_L, c);
		`RCT_CHK(v != 8'h00 && v < c, 1'b1)
		rdc(`RCT_IDX_CTRL, 8'h4d);
		`RCT_CHK(irq, 1'b1)
		wr(`RCT_IDX_CTRL, 8'h00);
	endtask
	task automatic t_baud;
		a0 = others;
		b0 = rx_n;
		d0 = tx_n;
		cyc(40);
		`RCT_CHK(rx_n - b0, others - a0)
		`RCT_CHK(tx_n - d0, others - a0)
		wr(`RCT_IDX_RCAP_L, 8'hf8);
		wr(`RCT_IDX_RCAP_H, 8'hff);
		wr(`RCT_IDX_CNT_L, 8'hf8);
		wr(`RCT_IDX_CNT_H, 8'hff);
		wr(`RCT_IDX_CTRL, 8'h3d);
		a0 = rx_n;
		b0 = tx_n;
		cyc(80);
		`RCT_CHK(rx_n - a0 >= 9 && rx_n - a0 <= 11, 1'b1)
		`RCT_CHK(tx_n - b0 >= 9 && tx_n - b0 <= 11, 1'b1)
		trig_fall();
		rdc(`RCT_IDX_CTRL, 8'h7d);
		wr(`RCT_IDX_CTRL, 8'h00);
	endtask
	task automatic t_updown;
		wr(`RCT_IDX_RCAP_L, 8'h00);
		wr(`RCT_IDX_RCAP_H, 8'h01);
		wr(`RCT_IDX_CNT_L, 8'h02);
		wr(`RCT_IDX_CNT_H, 8'h01);
		wr(`RCT_IDX_MODE, 8'h01);
		trig <= 1'b0;
		wr(`RCT_IDX_CTRL, 8'h0c);
		cyc(10);
		rdc(`RCT_IDX_CNT_H, 8'hff);
		rdc(`RCT_IDX_CTRL, 8'hcc);
		wr(`RCT_IDX_CTRL, 8'h48);
		cyc(1);
		`RCT_CHK(irq, 1'b0)
		trig <= 1'b1;
		wr(`RCT_IDX_CTRL, 8'h0c);
		cyc(30);
		rdc(`RCT_IDX_CNT_H, 8'h01);
		wr(`RCT_IDX_CTRL, 8'h00);
	endtask
	initial
	begin
		miscompares = 0;
		compares = 0;
		cyc(16);
		ARST_N <= 1'b1;
		t_regs();
		t_presc();
		t_counter();
		t_reload();
		t_capture();
		t_baud();
		t_updown();
		close_out();
	end
endmodule
